// ### core/cslp_cfg.svh
// Offsets, field positions, reset values and wait counts for the clock control block
// Included by the top module and the testbench; definitions only
`ifndef CSLP_CFG_SVH
`define CSLP_CFG_SVH

`define CSLP_OFF_CTRL       8'h00
`define CSLP_OFF_WAIT       8'h04
`define CSLP_OFF_DIV        8'h08
`define CSLP_OFF_LPM        8'h0C
`define CSLP_OFF_STATUS     8'h10
`define CSLP_OFF_IRQ_STAT   8'h14
`define CSLP_OFF_IRQ_MASK   8'h18

`define CSLP_CTRL_MAIN_EN   0
`define CSLP_CTRL_FAST_EN   1
`define CSLP_CTRL_SUB_EN    2
`define CSLP_CTRL_SRC_LSB   3
`define CSLP_CTRL_AUTO_LSB  5
`define CSLP_CTRL_AUTO_EN   7
`define CSLP_CTRL_RST       8'h04

`define CSLP_WAIT_RST       16'h00FF
`define CSLP_DIV_RST        16'h0000
`define CSLP_LOW_WAIT       16'h0004
`define CSLP_FAST_WAIT      16'h0010
`define CSLP_SUB_WAIT       16'h0040

`define CSLP_LPM_SLEEP      3'h1
`define CSLP_LPM_DSLEEP     3'h2
`define CSLP_LPM_SSTBY      3'h3
`define CSLP_LPM_MSTOP      3'h4
`define CSLP_LPM_DSSTBY     3'h5

`define CSLP_STAT_MODE_LSB  4
`define CSLP_STAT_SRC_LSB   10

`define CSLP_RESP_OKAY      2'h0
`define CSLP_RESP_SLVERR    2'h2

`define CSLP_INIT_LOAD      2'h2
`define CSLP_INIT_DONE      2'h3

`endif

// ### core/cslp_clk_div.sv
// Programmable divider producing a one-cycle enable every ratio+1 cycles
// Assumes ratio is a register on the same clock
`timescale 1ns/1ps
`default_nettype none
module cslp_clk_div #(
  parameter int DIV_W = 4
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [DIV_W-1:0] ratio,
  output var  logic             tick_reg
);

  logic [DIV_W-1:0] cnt_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end
    else if (cnt_reg >= ratio)
    begin
      cnt_reg  <= '0;
      tick_reg <= 1'b1;
    end
    else
    begin
      cnt_reg  <= cnt_reg + DIV_W'(1);
      tick_reg <= 1'b0;
    end
  end

  a_div_spacing: assert property (@(posedge aclk) disable iff (!aresetn)
    (tick_reg && ratio != '0 && $stable(ratio)) |=> !tick_reg)
    else $error("divider ticked twice in a row with nonzero ratio");

endmodule // cslp_clk_div
`default_nettype wire

// ### core/cslp_pkg.sv
// Types shared by the clock control block
// No assumptions beyond a SystemVerilog compiler
package cslp_pkg;

  typedef enum logic [5:0] {
    CSLP_RUN    = 6'b000001,
    CSLP_SLEEP  = 6'b000010,
    CSLP_DSLEEP = 6'b000100,
    CSLP_SSTBY  = 6'b001000,
    CSLP_MSTOP  = 6'b010000,
    CSLP_DSSTBY = 6'b100000
  } cslp_mode_type;

  typedef enum logic [1:0] {
    CSLP_SRC_LOW  = 2'h0,
    CSLP_SRC_FAST = 2'h1,
    CSLP_SRC_MAIN = 2'h2,
    CSLP_SRC_SUB  = 2'h3
  } cslp_src_type;

endpackage

// ### core/cslp_top.sv
// Clock source selection, stabilization wait and low-power clock gating
// Assumes one 40 MHz aclk; strap and wake pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "cslp_cfg.svh"
module cslp_top #(
  parameter int ADDR_W = 8,
  parameter int DIV_W  = 4,
  parameter int WAIT_W = 16
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output var  logic                 s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output var  logic                 s_axi_wready,
  output var  logic [1:0]           s_axi_bresp,
  output var  logic                 s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output var  logic                 s_axi_arready,
  output var  logic [31:0]          s_axi_rdata,
  output var  logic [1:0]           s_axi_rresp,
  output var  logic                 s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 fast_osc_reset_enable,
  input  wire logic                 wake_req,
  output var  logic                 low_speed_internal_osc_en,
  output var  logic                 high_speed_internal_osc_en,
  output var  logic                 main_osc_en,
  output var  logic                 sub_osc_en,
  output var  cslp_pkg::cslp_src_type src_sel,
  output var  logic                 cpu_clk_en,
  output var  logic                 dma_clk_en,
  output var  logic                 data_transfer_controller_clk_en,
  output var  logic                 rom_clk_en,
  output var  logic                 ram_clk_en,
  output var  logic                 periph_clk_en,
  output var  logic [3:0]           div_tick,
  output var  logic                 irq
);
  import cslp_pkg::*;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [7:0]          ctrl_reg;
  logic [WAIT_W-1:0]   main_osc_wait_count_reg;
  logic [4*DIV_W-1:0]  div_reg;
  cslp_mode_type       mode_reg;
  cslp_mode_type       mode_next;
  logic [4:0]          irq_stat_reg;
  logic [4:0]          irq_mask_reg;
  logic [3:0]          osc_on_reg;
  logic [3:0]          stable;
  logic [3:0]          stable_d_reg;
  logic [WAIT_W-1:0]   wait_load [4];
  logic                strap_s1_reg;
  logic                strap_s2_reg;
  logic                wake_s1_reg;
  logic                wake_s2_reg;
  logic [1:0]          init_cnt_reg;
  logic                aw_got_reg;
  logic                w_got_reg;
  logic [ADDR_W-1:0]   awaddr_reg;
  logic [31:0]         wdata_reg;
  logic [3:0]          wstrb_reg;
  logic [31:0]         wmask;
  logic                wr_fire;
  logic                wr_hit;
  logic [31:0]         rd_val;
  logic                rd_hit;
  logic                src_stable;
  logic                sleep_exit;
  logic                osc_halt;
  cslp_src_type        cur_src;

  assign cur_src    = cslp_src_type'(ctrl_reg[`CSLP_CTRL_SRC_LSB +: 2]);
  assign src_stable = stable[cur_src];
  assign osc_halt   = (mode_reg == CSLP_SSTBY) || (mode_reg == CSLP_DSSTBY);
  assign sleep_exit = (mode_reg == CSLP_SLEEP) && wake_s2_reg;
  assign wmask      = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  assign wr_fire    = aw_got_reg && w_got_reg && !s_axi_bvalid;

  // Two-stage synchronisers for the asynchronous pins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      strap_s1_reg <= 1'b0;
      strap_s2_reg <= 1'b0;
      wake_s1_reg  <= 1'b0;
      wake_s2_reg  <= 1'b0;
    end
    else
    begin
      strap_s1_reg <= fast_osc_reset_enable;
      strap_s2_reg <= strap_s1_reg;
      wake_s1_reg  <= wake_req;
      wake_s2_reg  <= wake_s1_reg;
    end
  end

  // Strap is taken once the synchroniser has filled after release
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      init_cnt_reg <= 2'h0;
    else if (init_cnt_reg != `CSLP_INIT_DONE)
      init_cnt_reg <= init_cnt_reg + 2'h1;
  end

  // Write address and data are taken independently, answered together
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CSLP_RESP_OKAY;
      aw_got_reg    <= 1'b0;
      w_got_reg     <= 1'b0;
      awaddr_reg    <= '0;
      wdata_reg     <= '0;
      wstrb_reg     <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_reg    <= 1'b1;
        awaddr_reg    <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_reg    <= 1'b1;
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_got_reg   <= 1'b0;
        w_got_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `CSLP_RESP_OKAY : `CSLP_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_comb
  begin
    wr_hit = 1'b1;
    unique case (awaddr_reg)
      ADDR_W'(`CSLP_OFF_CTRL), ADDR_W'(`CSLP_OFF_WAIT), ADDR_W'(`CSLP_OFF_DIV),
      ADDR_W'(`CSLP_OFF_LPM), ADDR_W'(`CSLP_OFF_STATUS), ADDR_W'(`CSLP_OFF_IRQ_STAT),
      ADDR_W'(`CSLP_OFF_IRQ_MASK): wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Control register; hardware source switch on sleep exit has the last word
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_reg <= `CSLP_CTRL_RST;
    else
    begin
      if (wr_fire && awaddr_reg == ADDR_W'(`CSLP_OFF_CTRL) && wstrb_reg[0])
        ctrl_reg <= wdata_reg[7:0];
      if (init_cnt_reg == `CSLP_INIT_LOAD)
        ctrl_reg[`CSLP_CTRL_FAST_EN] <= strap_s2_reg;
      if (sleep_exit && ctrl_reg[`CSLP_CTRL_AUTO_EN])
        ctrl_reg[`CSLP_CTRL_SRC_LSB +: 2] <= ctrl_reg[`CSLP_CTRL_AUTO_LSB +: 2];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      main_osc_wait_count_reg <= WAIT_W'(`CSLP_WAIT_RST);
      div_reg                 <= (4*DIV_W)'(`CSLP_DIV_RST);
      irq_mask_reg            <= '0;
    end
    else if (wr_fire)
    begin
      if (awaddr_reg == ADDR_W'(`CSLP_OFF_WAIT))
        main_osc_wait_count_reg <= WAIT_W'((main_osc_wait_count_reg & ~wmask)
                                           | (wdata_reg & wmask));
      if (awaddr_reg == ADDR_W'(`CSLP_OFF_DIV))
        div_reg <= (4*DIV_W)'((div_reg & ~wmask) | (wdata_reg & wmask));
      if (awaddr_reg == ADDR_W'(`CSLP_OFF_IRQ_MASK) && wstrb_reg[0])
        irq_mask_reg <= wdata_reg[4:0];
    end
  end

  always_comb
  begin
    mode_next = mode_reg;
    unique case (mode_reg)
      CSLP_RUN:
        if (wr_fire && awaddr_reg == ADDR_W'(`CSLP_OFF_LPM) && wstrb_reg[0])
        begin
          case (wdata_reg[2:0])
            `CSLP_LPM_SLEEP:  mode_next = CSLP_SLEEP;
            `CSLP_LPM_DSLEEP: mode_next = CSLP_DSLEEP;
            `CSLP_LPM_SSTBY:  mode_next = CSLP_SSTBY;
            `CSLP_LPM_MSTOP:  mode_next = CSLP_MSTOP;
            `CSLP_LPM_DSSTBY: mode_next = CSLP_DSSTBY;
            default:          mode_next = CSLP_RUN;
          endcase
        end
      CSLP_SLEEP, CSLP_DSLEEP, CSLP_SSTBY, CSLP_MSTOP:
        if (wake_s2_reg)
          mode_next = CSLP_RUN;
      CSLP_DSSTBY:
        mode_next = CSLP_DSSTBY;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mode_reg <= CSLP_RUN;
    else
      mode_reg <= mode_next;
  end

  // Oscillator enables; standby modes stop all but the sub-clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      osc_on_reg <= 4'b1001;
    else
    begin
      osc_on_reg[CSLP_SRC_LOW]  <= !osc_halt;
      osc_on_reg[CSLP_SRC_FAST] <= ctrl_reg[`CSLP_CTRL_FAST_EN] && !osc_halt;
      osc_on_reg[CSLP_SRC_MAIN] <= ctrl_reg[`CSLP_CTRL_MAIN_EN] && !osc_halt;
      osc_on_reg[CSLP_SRC_SUB]  <= ctrl_reg[`CSLP_CTRL_SUB_EN];
    end
  end

  assign wait_load[CSLP_SRC_LOW]  = WAIT_W'(`CSLP_LOW_WAIT);
  assign wait_load[CSLP_SRC_FAST] = WAIT_W'(`CSLP_FAST_WAIT);
  assign wait_load[CSLP_SRC_MAIN] = main_osc_wait_count_reg;
  assign wait_load[CSLP_SRC_SUB]  = WAIT_W'(`CSLP_SUB_WAIT);

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_osc
      cslp_wait_counter #(.WAIT_W(WAIT_W)) u_wait (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .osc_on     (osc_on_reg[gi]),
        .load_val   (wait_load[gi]),
        .stable_reg (stable[gi])
      );
      cslp_clk_div #(.DIV_W(DIV_W)) u_div (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .ratio    (div_reg[gi*DIV_W +: DIV_W]),
        .tick_reg (div_tick[gi])
      );
    end
  endgenerate

  // Clock gates per mode; CPU also waits for its source to stabilise
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cpu_clk_en                      <= 1'b0;
      dma_clk_en                      <= 1'b0;
      data_transfer_controller_clk_en <= 1'b0;
      rom_clk_en                      <= 1'b0;
      ram_clk_en                      <= 1'b0;
      periph_clk_en                   <= 1'b0;
    end
    else
    begin
      cpu_clk_en <= (mode_reg == CSLP_RUN) && src_stable;
      dma_clk_en <= (mode_reg == CSLP_RUN) || (mode_reg == CSLP_SLEEP);
      data_transfer_controller_clk_en <= (mode_reg == CSLP_RUN) || (mode_reg == CSLP_SLEEP);
      rom_clk_en <= (mode_reg == CSLP_RUN) || (mode_reg == CSLP_SLEEP);
      ram_clk_en <= (mode_reg == CSLP_RUN) || (mode_reg == CSLP_SLEEP);
      periph_clk_en <= (mode_reg == CSLP_RUN) || (mode_reg == CSLP_SLEEP)
                       || (mode_reg == CSLP_DSLEEP);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      low_speed_internal_osc_en  <= 1'b1;
      high_speed_internal_osc_en <= 1'b0;
      main_osc_en                <= 1'b0;
      sub_osc_en                 <= 1'b1;
      src_sel                    <= CSLP_SRC_LOW;
    end
    else
    begin
      low_speed_internal_osc_en  <= osc_on_reg[CSLP_SRC_LOW];
      high_speed_internal_osc_en <= osc_on_reg[CSLP_SRC_FAST];
      main_osc_en                <= osc_on_reg[CSLP_SRC_MAIN];
      sub_osc_en                 <= osc_on_reg[CSLP_SRC_SUB];
      src_sel                    <= cur_src;
    end
  end

  // Sticky events: stable rises and wake-up; set wins over a write-one clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stable_d_reg <= '0;
      irq_stat_reg <= '0;
      irq          <= 1'b0;
    end
    else
    begin
      stable_d_reg <= stable;
      irq_stat_reg <= (irq_stat_reg & ~((wr_fire && wstrb_reg[0]
                       && awaddr_reg == ADDR_W'(`CSLP_OFF_IRQ_STAT)) ? wdata_reg[4:0] : 5'h0))
                      | {(mode_reg != CSLP_RUN) && (mode_next == CSLP_RUN),
                         stable & ~stable_d_reg};
      irq          <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  always_comb
  begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      ADDR_W'(`CSLP_OFF_CTRL):     rd_val[7:0] = ctrl_reg;
      ADDR_W'(`CSLP_OFF_WAIT):     rd_val[WAIT_W-1:0] = main_osc_wait_count_reg;
      ADDR_W'(`CSLP_OFF_DIV):      rd_val[4*DIV_W-1:0] = div_reg;
      ADDR_W'(`CSLP_OFF_LPM):      rd_val = 32'h0000_0000;
      ADDR_W'(`CSLP_OFF_STATUS):
      begin
        rd_val[3:0] = stable;
        rd_val[`CSLP_STAT_MODE_LSB +: 6] = mode_reg;
        rd_val[`CSLP_STAT_SRC_LSB +: 2]  = cur_src;
      end
      ADDR_W'(`CSLP_OFF_IRQ_STAT): rd_val[4:0] = irq_stat_reg;
      ADDR_W'(`CSLP_OFF_IRQ_MASK): rd_val[4:0] = irq_mask_reg;
      default:                     rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `CSLP_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_hit ? `CSLP_RESP_OKAY : `CSLP_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  sequence s_strap_load;
    init_cnt_reg == `CSLP_INIT_LOAD ##1 1'b1;
  endsequence

  a_strap_fast_en: assert property (s_strap_load |-> ctrl_reg[`CSLP_CTRL_FAST_EN]
    == $past(strap_s2_reg))
    else $error("fast oscillator enable not taken from strap");
  a_reset_low_src: assert property ((init_cnt_reg != `CSLP_INIT_DONE)
    |-> cur_src == CSLP_SRC_LOW && osc_on_reg[CSLP_SRC_LOW] && osc_on_reg[CSLP_SRC_SUB])
    else $error("low-speed oscillator not the source after reset");
  a_cpu_gate_wait: assert property (cpu_clk_en |-> $past(src_stable)
    && $past(mode_reg) == CSLP_RUN)
    else $error("CPU clock delivered before source stable");
  a_sleep_cpu_off: assert property ((mode_reg == CSLP_SLEEP) |=> !cpu_clk_en
    && dma_clk_en && ram_clk_en && periph_clk_en)
    else $error("sleep gating wrong");
  a_sleep_auto_src: assert property ((sleep_exit && ctrl_reg[`CSLP_CTRL_AUTO_EN])
    |=> mode_reg == CSLP_RUN && cur_src == $past(ctrl_reg[`CSLP_CTRL_AUTO_LSB +: 2]))
    else $error("source not switched on sleep exit");
  a_dsleep_gates: assert property ((mode_reg == CSLP_DSLEEP) |=> !cpu_clk_en
    && !dma_clk_en && !data_transfer_controller_clk_en && !rom_clk_en && !ram_clk_en)
    else $error("deep sleep left a memory or bus master clock running");
  a_dsleep_periph: assert property ((mode_reg == CSLP_DSLEEP) |=> periph_clk_en)
    else $error("deep sleep stopped peripheral clock");
  a_dss_no_wake: assert property ((mode_reg == CSLP_DSSTBY) |=> mode_reg == CSLP_DSSTBY)
    else $error("deep software standby left without reset");
  a_standby_osc: assert property ((mode_reg == CSLP_SSTBY) |=> ##1 !main_osc_en
    && !stable[CSLP_SRC_MAIN])
    else $error("main oscillator kept running in standby");
  a_mode_onehot: assert property ($onehot(mode_reg))
    else $error("mode state not one-hot");

endmodule // cslp_top
`default_nettype wire

// ### core/cslp_wait_counter.sv
// Oscillation stabilization wait counter for one oscillator
// Assumes osc_on comes from a register on the same clock
`timescale 1ns/1ps
`default_nettype none
module cslp_wait_counter #(
  parameter int WAIT_W = 16
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              osc_on,
  input  wire logic [WAIT_W-1:0] load_val,
  output var  logic              stable_reg
);

  logic [WAIT_W-1:0] cnt_reg;
  logic              loaded_reg;

  // Reloaded while stopped, so every restart waits the full interval;
  // an oscillator running out of reset is loaded first, so start-up waits too
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_reg    <= '0;
      loaded_reg <= 1'b0;
      stable_reg <= 1'b0;
    end
    else if (!osc_on || !loaded_reg)
    begin
      cnt_reg    <= load_val;
      loaded_reg <= 1'b1;
      stable_reg <= 1'b0;
    end
    else if (cnt_reg != '0)
      cnt_reg <= cnt_reg - WAIT_W'(1);
    else
      stable_reg <= 1'b1;
  end

  a_wait_expiry: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(stable_reg) |-> $past(cnt_reg) == '0 && $past(osc_on))
    else $error("stable flag rose before wait count expired");

  a_wait_restart: assert property (@(posedge aclk) disable iff (!aresetn)
    !osc_on |=> !stable_reg ##1 (!stable_reg || $past(osc_on)))
    else $error("stable flag survived an oscillator stop");

endmodule // cslp_wait_counter
`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench for the clock control block: bus, waits, modes, dividers
// Assumes the core files compile first; the bench drives every input itself
`timescale 1ns/1ps
`default_nettype none
`include "cslp_cfg.svh"
module testbench;
  import cslp_pkg::*;
  logic         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic         s_axi_arvalid, s_axi_rready, fast_osc_reset_enable, wake_req;
  logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]   s_axi_awaddr, s_axi_araddr;
  logic [31:0]  s_axi_wdata, s_axi_rdata, d;
  logic [3:0]   s_axi_wstrb, div_tick;
  logic [1:0]   s_axi_bresp, s_axi_rresp, r;
  logic         low_speed_internal_osc_en, high_speed_internal_osc_en, main_osc_en;
  logic         sub_osc_en, cpu_clk_en, dma_clk_en, data_transfer_controller_clk_en;
  logic         rom_clk_en, ram_clk_en, periph_clk_en, irq;
  cslp_src_type src_sel;
  int           mismatches, cmp_count, m_ctrl, v, n, i;
  cslp_top cslp_top_inst (.*);
  initial
  begin
    aclk = 0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    s_axi_awaddr <= a;
    s_axi_wdata <= w;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    if (n == 50) mismatches++;
    r = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    if (n == 50) mismatches++;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
    chk(r, 0);
  endtask
  // Gate vector: cpu, dma, transfer, rom, ram, peripheral, low oscillator
  task automatic lpm(input int code, input logic [6:0] g);
    wr(`CSLP_OFF_LPM, code);
    cyc(3);
    chk({cpu_clk_en, dma_clk_en, data_transfer_controller_clk_en, rom_clk_en,
         ram_clk_en, periph_clk_en, low_speed_internal_osc_en}, g);
    rd(`CSLP_OFF_STATUS);
    chk(d[9:4], 1 << code);
    wake_req <= 1;
    for (i = 0; i < 40 && low_speed_internal_osc_en !== 1; i++) cyc(1);
    for (i = 0; i < 3; i++)
    begin
      cyc(1);
      if (code == 3) chk(cpu_clk_en, 0);
    end
    wake_req <= 0;
    for (i = 0; i < 40 && cpu_clk_en !== 1; i++) cyc(1);
    chk(cpu_clk_en, 1);
    $display("test low power mode %0d done", code);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #200_000;
    mismatches++;
    end_sim();
  end
  initial
  begin
    void'($urandom(99));
    {aresetn, s_axi_awvalid, s_axi_wvalid, wake_req} = '0;
    {s_axi_arvalid, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    // Response ready held high: every answer is taken at the edge it is seen
    {s_axi_bready, s_axi_rready} = 2'b11;
    s_axi_wstrb = 4'hF;
    fast_osc_reset_enable = 1'($urandom % 2);
    cyc(3);
    aresetn <= 1;
    cyc(`CSLP_LOW_WAIT + 2);
    chk({low_speed_internal_osc_en, sub_osc_en, main_osc_en, cpu_clk_en}, 4'hC);
    cyc(20);
    chk(high_speed_internal_osc_en, fast_osc_reset_enable);
    chk({cpu_clk_en, src_sel}, {1'b1, CSLP_SRC_LOW});
    m_ctrl = 4 | (fast_osc_reset_enable << 1);
    rc(`CSLP_OFF_CTRL, m_ctrl);
    rc(`CSLP_OFF_WAIT, 32'h0000_00FF);
    wr(8'h1C, 32'h0000_FFFF);
    chk(r, `CSLP_RESP_SLVERR);
    rd(8'h1C);
    chk({r, d}, {`CSLP_RESP_SLVERR, 32'h0000_0000});
    wr(`CSLP_OFF_LPM, 6);
    chk(r, `CSLP_RESP_OKAY);
    rd(`CSLP_OFF_STATUS);
    chk(d[9:4], 1);
    $display("test reset and map done");
    v = $urandom & 32'h0000_7777;
    wr(`CSLP_OFF_DIV, v);
    rc(`CSLP_OFF_DIV, v);
    for (int k = 0; k < 4; k++)
    begin
      for (i = 0; i < 20 && div_tick[k] !== 1; i++) cyc(1);
      cyc(1);
      for (i = 1; i < 20 && div_tick[k] !== 1; i++) cyc(1);
      chk(i, ((v >> (4 * k)) & 7) + 1);
    end
    $display("test dividers done");
    v = 20 + $urandom % 40;
    wr(`CSLP_OFF_WAIT, v);
    m_ctrl = (m_ctrl | 8'h11) & ~8'h04;
    wr(`CSLP_OFF_CTRL, m_ctrl);
    cyc(2);
    n = 0;
    repeat (v - 4)
    begin
      cyc(1);
      n += (cpu_clk_en !== 0);
    end
    chk(n, 0);
    for (i = 0; i < 20 && cpu_clk_en !== 1; i++) cyc(1);
    chk({cpu_clk_en, main_osc_en, sub_osc_en, src_sel}, {3'b110, CSLP_SRC_MAIN});
    cyc(2 * v);
    rd(`CSLP_OFF_STATUS);
    chk({d[11:10], d[2]}, 3'b101);
    $display("test main wait done");
    wr(`CSLP_OFF_IRQ_MASK, 8'h1F);
    cyc(3);
    chk(irq, 1);
    wr(`CSLP_OFF_IRQ_STAT, 8'h1F);
    cyc(3);
    chk(irq, 0);
    rc(`CSLP_OFF_IRQ_STAT, 0);
    m_ctrl = m_ctrl | 8'h80;
    wr(`CSLP_OFF_CTRL, m_ctrl);
    lpm(1, 7'h3F);
    m_ctrl = m_ctrl & ~8'h18;
    chk(src_sel, CSLP_SRC_LOW);
    rc(`CSLP_OFF_CTRL, m_ctrl);
    lpm(2, 7'h03);
    lpm(3, 7'h00);
    lpm(4, 7'h01);
    chk(irq, 1);
    wr(`CSLP_OFF_IRQ_MASK, 0);
    cyc(3);
    chk(irq, 0);
    rd(`CSLP_OFF_IRQ_STAT);
    chk(d[4], 1);
    $display("test interrupts done");
    wr(`CSLP_OFF_LPM, 5);
    wake_req <= 1;
    cyc(20);
    chk({cpu_clk_en, low_speed_internal_osc_en}, 0);
    wake_req <= 0;
    aresetn <= 0;
    cyc(3);
    aresetn <= 1;
    cyc(20);
    chk(cpu_clk_en, 1);
    rc(`CSLP_OFF_CTRL, 4 | (fast_osc_reset_enable << 1));
    $display("test deep standby done");
    end_sim();
  end
endmodule // testbench
`default_nettype wire
